// ### core/timer2_reload_capture.sv
/*
 * sixteen-bit auto-reload timer with split 8-bit mode and low-frequency
 * oscillator capture, with an apb register slave and one level interrupt.
 * assumes apb signals synchronous to REF_CLK; EXT_CLK and LFO_CLK are
 * asynchronous and are synchronised here.
 */
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - count is a low byte and a high byte forming one 16-bit counter while the split bit is clear
// - tick source is system clock, system clock over 12, or external over 8
// - external clock is synchronised before its divide-by-8 tick advances the count
// - split bit clear: one 16-bit up-counter with auto-reload
// - 16-bit rollover loads the reload pair and sets the high overflow flag
// - timer interrupt on high overflow when timer interrupts are enabled
// - in 16-bit mode low-byte rollover also interrupts when low enable set
// - split bit set: two independent 8-bit reload counters, each own reload
// - in split mode run bit gates only the high counter
// - per half: select bit 1 gives system clock, else external select decides
// - high and low overflow flags set on their byte rolling ff to 00
// - split mode: high overflow interrupts, low one too when enabled
// - overflow flags are cleared only by software writes
// - capture enable with oscillator source replaces reload with capture
// - capture, 16-bit: free run, capture copies count into reload pair
// - capture, split: bytes wrap alone, capture copies both into reloads
// - capture source value 1 is oscillator falling edge; 0 captures nothing
// - outside split mode the timer advances only while run is set
module timer2_reload_capture (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLK,
  input wire logic LFO_CLK,
  output logic IRQ
);

  // ==========================================================
  // register state
  timer2_pkg::timer2_control_t ctrl_q;
  timer2_pkg::clock_control_t clk_sel_q;
  timer2_pkg::event_t status_q;
  timer2_pkg::event_t mask_q;
  timer2_pkg::event_t events;
  logic [7:0] cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
  logic [7:0] rl_lo_q, rl_hi_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  logic wr_en, rd_en, addr_ok;

  // ==========================================================
  // apb slave: one wait state, answer on the second access cycle
  assign wr_en = PSEL && PENABLE && PWRITE && pready_q;
  assign rd_en = PSEL && PENABLE && !PWRITE && !pready_q;
  assign addr_ok = (PADDR == timer2_pkg::CONTROL_OFS) || (PADDR == timer2_pkg::COUNT_LOW_OFS)
    || (PADDR == timer2_pkg::COUNT_HIGH_OFS) || (PADDR == timer2_pkg::RELOAD_LOW_OFS)
    || (PADDR == timer2_pkg::RELOAD_HIGH_OFS) || (PADDR == timer2_pkg::CLOCK_CONTROL_OFS)
    || (PADDR == timer2_pkg::IRQ_STATUS_OFS) || (PADDR == timer2_pkg::IRQ_MASK_OFS);

  // ready and error handshake
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
      pslverr_q <= PSEL && PENABLE && !pready_q && !addr_ok;
    end
  end

  // read data mux, captured one cycle before ready
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (PADDR)
        timer2_pkg::CONTROL_OFS: prdata_q <= {24'h00_0000, ctrl_q};
        timer2_pkg::COUNT_LOW_OFS: prdata_q <= {24'h00_0000, cnt_lo_q};
        timer2_pkg::COUNT_HIGH_OFS: prdata_q <= {24'h00_0000, cnt_hi_q};
        timer2_pkg::RELOAD_LOW_OFS: prdata_q <= {24'h00_0000, rl_lo_q};
        timer2_pkg::RELOAD_HIGH_OFS: prdata_q <= {24'h00_0000, rl_hi_q};
        timer2_pkg::CLOCK_CONTROL_OFS: prdata_q <= {29'h0000_0000, clk_sel_q};
        timer2_pkg::IRQ_STATUS_OFS: prdata_q <= {29'h0000_0000, status_q};
        timer2_pkg::IRQ_MASK_OFS: prdata_q <= {29'h0000_0000, mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end else if (!PSEL) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // tick sources
  logic [3:0] pre_q;
  logic div12_tick;
  logic ext_s1, ext_s2, ext_s3;
  logic [2:0] ext_div_q;
  logic ext_tick_q;
  logic lfo_s1, lfo_s2, lfo_s3;
  logic cap_strobe;
  logic cap_mode;
  logic tick_lo, tick_hi, slow_tick;

  // system clock divided by 12
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pre_q <= 4'h0;
    end else if (pre_q == timer2_pkg::SYSTEM_CLOCK_DIV_LAST) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end
  assign div12_tick = (pre_q == timer2_pkg::SYSTEM_CLOCK_DIV_LAST);

  // external clock: synchroniser, rising edge, divide by 8
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_div_q <= 3'h0;
      ext_tick_q <= 1'b0;
    end else begin
      ext_s1 <= EXT_CLK;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_tick_q <= 1'b0;
      if (ext_s2 && !ext_s3) begin
        ext_div_q <= ext_div_q + 3'h1;
        ext_tick_q <= (ext_div_q == timer2_pkg::EXT_DIV_LAST);
      end
    end
  end

  // oscillator synchroniser and falling edge strobe
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      lfo_s1 <= 1'b0;
      lfo_s2 <= 1'b0;
      lfo_s3 <= 1'b0;
    end else begin
      lfo_s1 <= LFO_CLK;
      lfo_s2 <= lfo_s1;
      lfo_s3 <= lfo_s2;
    end
  end
  assign cap_strobe = lfo_s3 && !lfo_s2;

  // per-half clock choice
  assign slow_tick = ctrl_q.external_clock_select ? ext_tick_q : div12_tick;
  assign tick_lo = clk_sel_q.low_half_clock_select ? 1'b1 : slow_tick;
  assign tick_hi = clk_sel_q.high_half_clock_select ? 1'b1 : slow_tick;

  // capture mode needs enable and the oscillator source
  assign cap_mode = ctrl_q.lfo_capture_enable && ctrl_q.capture_source_select;

  // ==========================================================
  // counter next state
  always_comb begin
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    events = '0;
    if (!ctrl_q.split_mode_bit) begin
      // one 16-bit counter, gated by run
      if (ctrl_q.run_control_bit && tick_lo) begin
        if ({cnt_hi_q, cnt_lo_q} == 16'hffff) begin
          events.high_ovf = 1'b1;
          events.low_ovf = 1'b1;
          if (cap_mode) begin
            {cnt_hi_d, cnt_lo_d} = 16'h0000;
          end else begin
            {cnt_hi_d, cnt_lo_d} = {rl_hi_q, rl_lo_q};
          end
        end else begin
          events.low_ovf = (cnt_lo_q == 8'hff);
          {cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
        end
      end
    end else begin
      // low half always runs
      if (tick_lo) begin
        if (cnt_lo_q == 8'hff) begin
          events.low_ovf = 1'b1;
          cnt_lo_d = cap_mode ? 8'h00 : rl_lo_q;
        end else begin
          cnt_lo_d = cnt_lo_q + 8'h01;
        end
      end
      // high half only while run is set
      if (ctrl_q.run_control_bit && tick_hi) begin
        if (cnt_hi_q == 8'hff) begin
          events.high_ovf = 1'b1;
          cnt_hi_d = cap_mode ? 8'h00 : rl_hi_q;
        end else begin
          cnt_hi_d = cnt_hi_q + 8'h01;
        end
      end
    end
    events.capture = cap_mode && cap_strobe;
    // software write to the count wins over counting
    if (wr_en && PADDR == timer2_pkg::COUNT_LOW_OFS) begin
      cnt_lo_d = PWDATA[7:0];
    end
    if (wr_en && PADDR == timer2_pkg::COUNT_HIGH_OFS) begin
      cnt_hi_d = PWDATA[7:0];
    end
  end

  // count registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnt_lo_q <= timer2_pkg::COUNT_RST;
      cnt_hi_q <= timer2_pkg::COUNT_RST;
    end else begin
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
    end
  end

  // reload registers; a capture wins over a software write
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rl_lo_q <= timer2_pkg::RELOAD_RST;
      rl_hi_q <= timer2_pkg::RELOAD_RST;
    end else if (events.capture) begin
      rl_lo_q <= cnt_lo_q;
      rl_hi_q <= cnt_hi_q;
    end else begin
      if (wr_en && PADDR == timer2_pkg::RELOAD_LOW_OFS) begin
        rl_lo_q <= PWDATA[7:0];
      end
      if (wr_en && PADDR == timer2_pkg::RELOAD_HIGH_OFS) begin
        rl_hi_q <= PWDATA[7:0];
      end
    end
  end

  // ==========================================================
  // control register; overflow set wins over a software clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_q <= timer2_pkg::CONTROL_RST;
    end else begin
      if (wr_en && PADDR == timer2_pkg::CONTROL_OFS) begin
        ctrl_q <= PWDATA[7:0];
      end
      if (events.high_ovf) begin
        ctrl_q.high_overflow_flag <= 1'b1;
      end
      if (events.low_ovf) begin
        ctrl_q.low_overflow_flag <= 1'b1;
      end
    end
  end

  // clock select and mask registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      clk_sel_q <= timer2_pkg::CLOCK_CONTROL_RST;
      mask_q <= timer2_pkg::IRQ_MASK_RST;
    end else if (wr_en) begin
      if (PADDR == timer2_pkg::CLOCK_CONTROL_OFS) begin
        clk_sel_q <= PWDATA[2:0];
      end
      if (PADDR == timer2_pkg::IRQ_MASK_OFS) begin
        mask_q <= PWDATA[2:0];
      end
    end
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      status_q <= '0;
    end else if (wr_en && PADDR == timer2_pkg::IRQ_STATUS_OFS) begin
      status_q <= (status_q & ~PWDATA[2:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // interrupt level: low overflow counts only with its own enable
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= clk_sel_q.timer_irq_enable
        && |(status_q & mask_q & {1'b1, ctrl_q.low_byte_irq_enable, 1'b1});
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_high_flag_set: assert property (events.high_ovf |=> ctrl_q.high_overflow_flag)
    else $error("high overflow flag not set");

  a_reload_on_wrap: assert property (!ctrl_q.split_mode_bit && !cap_mode && ctrl_q.run_control_bit
    && tick_lo && {cnt_hi_q, cnt_lo_q} == 16'hffff && !wr_en
    |=> {cnt_hi_q, cnt_lo_q} == {$past(rl_hi_q), $past(rl_lo_q)})
    else $error("reload pair not loaded on rollover");

  a_split_low_runs: assert property (ctrl_q.split_mode_bit && tick_lo && cnt_lo_q != 8'hff && !wr_en
    |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
    else $error("low half did not advance in split mode");

  a_split_high_held: assert property (ctrl_q.split_mode_bit && !ctrl_q.run_control_bit && !wr_en
    |=> cnt_hi_q == $past(cnt_hi_q))
    else $error("high half moved while stopped");

  a_stopped_16bit: assert property (!ctrl_q.split_mode_bit && !ctrl_q.run_control_bit && !wr_en
    |=> $stable({cnt_hi_q, cnt_lo_q}))
    else $error("16-bit count moved while stopped");

  a_capture_latch: assert property (cap_mode && lfo_s3 && !lfo_s2
    |=> {rl_hi_q, rl_lo_q} == $past({cnt_hi_q, cnt_lo_q}))
    else $error("capture did not latch count");

  a_ext_tick_space: assert property (ext_tick_q |=> !ext_tick_q [*8])
    else $error("external tick faster than divide by 8");

  a_flag_kept: assert property (ctrl_q.low_overflow_flag && !(wr_en && PADDR == timer2_pkg::CONTROL_OFS)
    |=> ctrl_q.low_overflow_flag)
    else $error("low overflow flag cleared by hardware");

  a_irq_on_high: assert property (clk_sel_q.timer_irq_enable && status_q.high_ovf && mask_q.high_ovf
    |=> irq_q)
    else $error("no interrupt after high overflow");

  a_low_irq_gated: assert property (!ctrl_q.low_byte_irq_enable && !status_q.high_ovf && !status_q.capture
    |=> !irq_q)
    else $error("low overflow interrupted without its enable");

  a_low_flag_set: assert property (events.low_ovf |=> ctrl_q.low_overflow_flag)
    else $error("low overflow flag not set");

  a_high_flag_kept: assert property (
    ctrl_q.high_overflow_flag && !(wr_en && PADDR == timer2_pkg::CONTROL_OFS) |=> ctrl_q.high_overflow_flag)
    else $error("high overflow flag cleared by hardware");

  a_split_low_reload: assert property (
    ctrl_q.split_mode_bit && !cap_mode && tick_lo && cnt_lo_q == 8'hff && !wr_en |=> cnt_lo_q == $past(rl_lo_q))
    else $error("low half not reloaded from its own register");

  a_split_high_reload: assert property (
    ctrl_q.split_mode_bit && !cap_mode && ctrl_q.run_control_bit && tick_hi && cnt_hi_q == 8'hff && !wr_en
    |=> cnt_hi_q == $past(rl_hi_q))
    else $error("high half not reloaded from its own register");

  a_split_capture_wrap: assert property (
    ctrl_q.split_mode_bit && cap_mode && tick_lo && cnt_lo_q == 8'hff && !wr_en |=> cnt_lo_q == 8'h00)
    else $error("low half did not wrap to zero in capture mode");

  a_capture_status: assert property (events.capture |=> status_q.capture)
    else $error("capture event not recorded");

  a_irq_quiet: assert property (!clk_sel_q.timer_irq_enable |=> !irq_q)
    else $error("interrupt raised while timer interrupts disabled");

endmodule

// ### core/timer2_pkg.sv
/*
 * constants, field layouts and reset values of the auto-reload and capture timer.
 * assumes a 32-bit apb register bus with one register per aligned word.
 */
package timer2_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] COUNT_LOW_OFS = 8'h04;
  localparam logic [7:0] COUNT_HIGH_OFS = 8'h08;
  localparam logic [7:0] RELOAD_LOW_OFS = 8'h0c;
  localparam logic [7:0] RELOAD_HIGH_OFS = 8'h10;
  localparam logic [7:0] CLOCK_CONTROL_OFS = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;

  // ==========================================================
  // field layouts, msb first
  typedef struct packed {
    logic high_overflow_flag;    // bit 7
    logic low_overflow_flag;     // bit 6
    logic low_byte_irq_enable;   // bit 5
    logic lfo_capture_enable;    // bit 4
    logic split_mode_bit;        // bit 3
    logic run_control_bit;       // bit 2
    logic capture_source_select; // bit 1
    logic external_clock_select; // bit 0
  } timer2_control_t;

  typedef struct packed {
    logic timer_irq_enable;       // bit 2
    logic high_half_clock_select; // bit 1
    logic low_half_clock_select;  // bit 0
  } clock_control_t;

  typedef struct packed {
    logic capture;  // bit 2
    logic low_ovf;  // bit 1
    logic high_ovf; // bit 0
  } event_t;

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] CLOCK_CONTROL_RST = 3'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ==========================================================
  // clock division ratios
  localparam logic [3:0] SYSTEM_CLOCK_DIV_LAST = 4'hb;  // divide by 12: counts 0..11
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;       // divide by 8: counts 0..7

endpackage

// ### bench/timer2_reload_capture_tb.sv
/*
 * self-checking bench for the auto-reload and capture timer: apb read and write
 * tasks, then reload, split, prescaler, external clock, capture and irq tests.
 * assumes the design answers each apb access with a one-cycle pready pulse.
 */
`timescale 1ns/1ps
module timer2_reload_capture_tb;
  logic REF_CLK, RST, PSEL, PENABLE, PWRITE, EXT_CLK, LFO_CLK, PREADY, PSLVERR, IRQ, er;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, keep;
  logic [7:0] ofs [6];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  timer2_reload_capture i_dut (
    .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_CLK(EXT_CLK), .LFO_CLK(LFO_CLK), .IRQ(IRQ)
  );

  // ==========================================================
  // clock, external oscillator at a quarter rate, timeout
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    EXT_CLK <= cyc[1];
    if (cyc == 20000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  // ==========================================================
  // comparisons and verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // apb master: setup, access held until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    // a wait that runs out counts as a mismatch
    if (PREADY !== 1'b1) begin
      check({31'h0, PREADY}, 32'h1);
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // read and compare the bits under a mask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd & m, exp);
  endtask

  // read until a masked bit shows, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) === 32'h0 && n < 300);
    check(rd & m, m);
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge REF_CLK);
    #1;
    check({31'h0, IRQ}, {31'h0, e});
  endtask

  // ==========================================================
  // test sequence
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    LFO_CLK = 1'b1;
    EXT_CLK = 1'b0;
    ofs = '{timer2_pkg::CONTROL_OFS, timer2_pkg::COUNT_LOW_OFS, timer2_pkg::COUNT_HIGH_OFS,
            timer2_pkg::RELOAD_LOW_OFS, timer2_pkg::CLOCK_CONTROL_OFS, timer2_pkg::IRQ_MASK_OFS};
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    // reset values, then an unmapped word
    foreach (ofs[i]) rdc(ofs[i], 32'hffffffff, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, er}, 32'h1);
    // 16-bit rollover loads the reload pair and sets the high flag
    wr(timer2_pkg::CLOCK_CONTROL_OFS, 32'h1);
    wr(timer2_pkg::RELOAD_LOW_OFS, 32'h34);
    wr(timer2_pkg::RELOAD_HIGH_OFS, 32'h12);
    wr(timer2_pkg::COUNT_LOW_OFS, 32'hfe);
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'hff);
    wr(timer2_pkg::CONTROL_OFS, 32'h04);
    poll(timer2_pkg::CONTROL_OFS, 32'h80);
    wr(timer2_pkg::CONTROL_OFS, 32'h80);
    rdc(timer2_pkg::COUNT_HIGH_OFS, 32'hff, 32'h12);
    rdc(timer2_pkg::CONTROL_OFS, 32'h80, 32'h80);
    // stopped outside split mode: the count holds
    apb(1'b0, timer2_pkg::COUNT_LOW_OFS, 32'h0);
    keep = rd;
    repeat (50) @(posedge REF_CLK);
    rdc(timer2_pkg::COUNT_LOW_OFS, 32'hff, keep);
    // overflow interrupt: masked, unmasked, cleared
    wr(timer2_pkg::CLOCK_CONTROL_OFS, 32'h5);
    irq_is(1'b0);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h1);
    irq_is(1'b1);
    wr(timer2_pkg::IRQ_STATUS_OFS, 32'h7);
    irq_is(1'b0);
    wr(timer2_pkg::CONTROL_OFS, 32'h00);
    rdc(timer2_pkg::CONTROL_OFS, 32'hff, 32'h0);
    // split mode, run clear: only the low byte counts and reloads
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'h05);
    wr(timer2_pkg::COUNT_LOW_OFS, 32'hfe);
    wr(timer2_pkg::RELOAD_LOW_OFS, 32'h40);
    wr(timer2_pkg::CONTROL_OFS, 32'h08);
    poll(timer2_pkg::CONTROL_OFS, 32'h40);
    rdc(timer2_pkg::COUNT_HIGH_OFS, 32'hff, 32'h05);
    rdc(timer2_pkg::IRQ_STATUS_OFS, 32'h2, 32'h2);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h2);
    irq_is(1'b0);
    wr(timer2_pkg::CONTROL_OFS, 32'h28);
    irq_is(1'b1);
    // split high byte on the divide-by-12 tick reloads from its own register
    wr(timer2_pkg::RELOAD_HIGH_OFS, 32'h77);
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'hfe);
    wr(timer2_pkg::CONTROL_OFS, 32'h0c);
    poll(timer2_pkg::CONTROL_OFS, 32'h80);
    wr(timer2_pkg::CONTROL_OFS, 32'h08);
    apb(1'b0, timer2_pkg::COUNT_HIGH_OFS, 32'h0);
    check_rng(rd, 32'h77, 32'h79);
    // 16-bit on the divide-by-12 tick: 240 cycles give 20 ticks
    wr(timer2_pkg::CLOCK_CONTROL_OFS, 32'h0);
    wr(timer2_pkg::COUNT_LOW_OFS, 32'h0);
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'h0);
    wr(timer2_pkg::CONTROL_OFS, 32'h04);
    repeat (240) @(posedge REF_CLK);
    wr(timer2_pkg::CONTROL_OFS, 32'h00);
    apb(1'b0, timer2_pkg::COUNT_LOW_OFS, 32'h0);
    check_rng(rd, 32'd19, 32'd21);
    // external clock over 8: one tick per 32 cycles, 320 cycles give 10
    wr(timer2_pkg::COUNT_LOW_OFS, 32'h0);
    wr(timer2_pkg::CONTROL_OFS, 32'h05);
    repeat (320) @(posedge REF_CLK);
    wr(timer2_pkg::CONTROL_OFS, 32'h01);
    apb(1'b0, timer2_pkg::COUNT_LOW_OFS, 32'h0);
    check_rng(rd, 32'd9, 32'd11);
    // reserved capture source: an oscillator fall captures nothing
    wr(timer2_pkg::IRQ_STATUS_OFS, 32'h7);
    wr(timer2_pkg::CLOCK_CONTROL_OFS, 32'h1);
    wr(timer2_pkg::CONTROL_OFS, 32'h14);
    repeat (10) @(posedge REF_CLK);
    LFO_CLK <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    LFO_CLK <= 1'b1;
    rdc(timer2_pkg::IRQ_STATUS_OFS, 32'h4, 32'h0);
    // capture: the count at the oscillator fall lands in the reload pair
    wr(timer2_pkg::CONTROL_OFS, 32'h00);
    wr(timer2_pkg::COUNT_LOW_OFS, 32'h0);
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'h0);
    wr(timer2_pkg::CONTROL_OFS, 32'h16);
    repeat (40) @(posedge REF_CLK);
    LFO_CLK <= 1'b0;
    repeat (20) @(posedge REF_CLK);
    wr(timer2_pkg::CONTROL_OFS, 32'h12);
    apb(1'b0, timer2_pkg::RELOAD_LOW_OFS, 32'h0);
    check_rng(rd, 32'd40, 32'd52);
    rdc(timer2_pkg::RELOAD_HIGH_OFS, 32'hff, 32'h0);
    rdc(timer2_pkg::IRQ_STATUS_OFS, 32'h4, 32'h4);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h4);
    wr(timer2_pkg::CLOCK_CONTROL_OFS, 32'h5);
    irq_is(1'b1);
    // split capture: the low byte wraps to zero, both bytes land in the reloads
    wr(timer2_pkg::COUNT_LOW_OFS, 32'hfe);
    LFO_CLK <= 1'b1;
    wr(timer2_pkg::COUNT_HIGH_OFS, 32'h33);
    wr(timer2_pkg::CONTROL_OFS, 32'h1a);
    repeat (20) @(posedge REF_CLK);
    LFO_CLK <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    wr(timer2_pkg::CONTROL_OFS, 32'h12);
    apb(1'b0, timer2_pkg::RELOAD_LOW_OFS, 32'h0);
    check_rng(rd, 32'd18, 32'd24);
    rdc(timer2_pkg::RELOAD_HIGH_OFS, 32'hff, 32'h33);
    finish_test();
  end
endmodule
